// ===== hdl/gpg_top.sv
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "gpg_cfg.svh"

// Behaviour
// - Data word: output latch high byte, pin input low byte; enables.
// - Flag word: per-pin flags low byte, write one clears them.
// - Control word: edge select high byte, interrupt enable low byte.
// - Mode bit 0 gives GPIO, 1 gives the chosen peripheral function.
// - Two-bit function field per pin at bits 2y+1..2y, reset zero.
// - Function 1 goes to the universal mux; fixed group-one functions.
// - Second group has six pins; unused bits read zero.
// - Second group function word uses bits 11..0 only.
// - Second group: converter trigger, reference and analog inputs.
// - Summary bit per group shows any pending flag in it.

module gpg_top #(
   parameter int FILT_DIV     = `GPG_FILT_DIV,
   parameter int FILT_SAMPLES = `GPG_FILT_SAMPLES
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             IRQ,
   input  wire logic [7:0]  G1_PIN_IN,
   output logic      [7:0]  G1_PIN_OUT,
   output logic      [7:0]  G1_PIN_OE_N,
   output logic      [7:0]  G1_PULL_EN,
   output logic      [7:0]  G1_PULL_UP,
   input  wire logic [5:0]  G2_PIN_IN,
   output logic      [5:0]  G2_PIN_OUT,
   output logic      [5:0]  G2_PIN_OE_N,
   output logic      [5:0]  G2_PULL_EN,
   output logic      [5:0]  G2_PULL_UP,
   input  wire logic [7:0]  UPM1_OUT,
   input  wire logic [7:0]  UPM1_DRV,
   output logic      [7:0]  UPM1_IN,
   input  wire logic [5:0]  UPM2_OUT,
   input  wire logic [5:0]  UPM2_DRV,
   output logic      [5:0]  UPM2_IN,
   output logic             EXTERNAL_CLOCK_INPUT,
   output logic             TIMER1_EXT_CLOCK_A,
   output logic             TIMER1_EXT_CLOCK_B,
   output logic             EXTERNAL_VOLTAGE_DETECT_INPUT,
   input  wire logic        REMOTE_CTRL_OUTPUT,
   input  wire logic        REMOTE_CARRIER_PULSE,
   output logic             CONVERTER_TRIGGER_N,
   output logic             CONVERTER_REFERENCE_SEL,
   output logic      [3:0]  CONVERTER_ANALOG_SEL
);

   localparam logic [7:0] GRP_MASK [2] = '{`GPG_G1_MASK, `GPG_G2_MASK};
   localparam logic [7:0] FN0_DRV  [2] = '{`GPG_G1_FN0_DRV,
                                           `GPG_G2_FN0_DRV};

   gpg_pkg::gpg_state_t s_q;
   gpg_pkg::gpg_state_t s_d;

   logic [7:0]  pin_raw [2];
   logic [7:0]  upm_out [2];
   logic [7:0]  upm_drv [2];
   logic [7:0]  fn0_out [2];
   logic [7:0]  ev      [2];
   logic [7:0]  drive   [2];
   logic [7:0]  pout    [2];
   logic [7:0]  route   [2][4];
   logic [1:0]  grp_hit;
   logic        sum_hit;
   logic        req;
   logic        wr_go;
   logic        tick;
   logic [7:0]  lane_lo;
   logic [7:0]  lane_hi;
   logic [2:0]  r_idx;
   logic [7:0]  grp_base;

   // ----------------------------------------------------------------
   // Pin and peripheral alignment to eight lanes
   // ----------------------------------------------------------------
   assign pin_raw[0] = G1_PIN_IN;
   assign pin_raw[1] = {2'h0, G2_PIN_IN};
   assign upm_out[0] = UPM1_OUT;
   assign upm_out[1] = {2'h0, UPM2_OUT};
   assign upm_drv[0] = UPM1_DRV;
   assign upm_drv[1] = {2'h0, UPM2_DRV};
   assign fn0_out[0] = {REMOTE_CARRIER_PULSE, REMOTE_CTRL_OUTPUT,
                        6'h00};
   assign fn0_out[1] = 8'h00;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign req      = WB_CYC_I & WB_STB_I;
   // Write lands on the edge where the master sees ack
   assign wr_go    = req & s_q.ack & WB_WE_I;
   assign lane_lo  = {8{WB_SEL_I[0]}};
   assign lane_hi  = {8{WB_SEL_I[1]}};
   assign r_idx    = WB_ADR_I[4:2];
   assign grp_base = {WB_ADR_I[`GPG_GRP_SEL_MSB:`GPG_GRP_SEL_LSB], 5'h00};
   assign grp_hit[0] = (grp_base == `GPG_G1_BASE) &&
                       (WB_ADR_I[1:0] == 2'h0);
   assign grp_hit[1] = (grp_base == `GPG_G2_BASE) &&
                       (WB_ADR_I[1:0] == 2'h0);
   assign sum_hit    = (WB_ADR_I == `GPG_SUMMARY_OFS);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] fn_mask(input logic [7:0] m);
      logic [15:0] r;
      r = 16'h0000;
      for (int y = 0; y < 8; y++)
      begin
         r[2*y +: 2] = {2{m[y]}};
      end
      return r;
   endfunction

   function automatic logic [7:0] merge8(input logic [7:0] old,
                                         input logic [7:0] d,
                                         input logic [7:0] lane,
                                         input logic [7:0] m);
      return ((old & ~lane) | (d & lane)) & m;
   endfunction

   function automatic logic [15:0] grp_read(
      input gpg_pkg::gpg_grp_t g,
      input logic [2:0]        idx);
      logic [15:0] r;
      r = 16'h0000;
      case (idx)
         `GPG_IDX_DATA: r = {g.out, g.pin & g.ien};
         `GPG_IDX_IOEN: r = {g.ien, g.oen};
         `GPG_IDX_PULL: r = {g.pdir, g.ren};
         `GPG_IDX_FLAG: r = {8'h00, g.flag};
         `GPG_IDX_ICTL: r = {g.edge_sel, g.ie};
         `GPG_IDX_FILT: r = {8'h00, g.filt};
         `GPG_IDX_MODE: r = {8'h00, g.mode};
         `GPG_IDX_FNC:  r = g.fnc;
         default:       r = 16'h0000;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Filter tick divider
   // ----------------------------------------------------------------
   assign tick = (s_q.div == `GPG_DIV_W'(FILT_DIV - 1));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0]  clr;
      logic [15:0] fm;
      clr = 8'h00;
      fm  = 16'h0000;
      s_d = s_q;

      s_d.div = tick ? '0 : s_q.div + `GPG_DIV_W'(1);

      // One wait state: ack rises the cycle after the request
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack)
      begin
         if (grp_hit[0])
            s_d.dat = grp_read(s_q.grp[0], r_idx);
         else if (grp_hit[1])
            s_d.dat = grp_read(s_q.grp[1], r_idx);
         else if (sum_hit)
         begin
            s_d.dat = 16'h0000;
            s_d.dat[`GPG_SUM_G1_BIT] = |s_q.grp[0].flag;
            s_d.dat[`GPG_SUM_G2_BIT] = |s_q.grp[1].flag;
         end
         else
            s_d.dat = 16'h0000;
      end

      for (int g = 0; g < 2; g++)
      begin
         clr = 8'h00;
         fm  = fn_mask(GRP_MASK[g]);
         // Synchronous pins; upper lanes of group two stay zero
         s_d.grp[g].pin = pin_raw[g] & GRP_MASK[g];
         if (wr_go && grp_hit[g])
         begin
            case (r_idx)
               `GPG_IDX_DATA:
               begin
                  s_d.grp[g].out = merge8(s_q.grp[g].out,
                     WB_DAT_I[`GPG_HI_LSB +: 8], lane_hi,
                     GRP_MASK[g]);
               end
               `GPG_IDX_IOEN:
               begin
                  s_d.grp[g].ien = merge8(s_q.grp[g].ien,
                     WB_DAT_I[`GPG_HI_LSB +: 8], lane_hi,
                     GRP_MASK[g]);
                  s_d.grp[g].oen = merge8(s_q.grp[g].oen,
                     WB_DAT_I[`GPG_LO_LSB +: 8], lane_lo,
                     GRP_MASK[g]);
               end
               `GPG_IDX_PULL:
               begin
                  s_d.grp[g].pdir = merge8(s_q.grp[g].pdir,
                     WB_DAT_I[`GPG_HI_LSB +: 8], lane_hi,
                     GRP_MASK[g]);
                  s_d.grp[g].ren = merge8(s_q.grp[g].ren,
                     WB_DAT_I[`GPG_LO_LSB +: 8], lane_lo,
                     GRP_MASK[g]);
               end
               `GPG_IDX_FLAG:
               begin
                  clr = WB_DAT_I[`GPG_LO_LSB +: 8] & lane_lo;
               end
               `GPG_IDX_ICTL:
               begin
                  s_d.grp[g].edge_sel = merge8(s_q.grp[g].edge_sel,
                     WB_DAT_I[`GPG_HI_LSB +: 8], lane_hi,
                     GRP_MASK[g]);
                  s_d.grp[g].ie = merge8(s_q.grp[g].ie,
                     WB_DAT_I[`GPG_LO_LSB +: 8], lane_lo,
                     GRP_MASK[g]);
               end
               `GPG_IDX_FILT:
               begin
                  s_d.grp[g].filt = merge8(s_q.grp[g].filt,
                     WB_DAT_I[`GPG_LO_LSB +: 8], lane_lo,
                     GRP_MASK[g]);
               end
               `GPG_IDX_MODE:
               begin
                  s_d.grp[g].mode = merge8(s_q.grp[g].mode,
                     WB_DAT_I[`GPG_LO_LSB +: 8], lane_lo,
                     GRP_MASK[g]);
               end
               `GPG_IDX_FNC:
               begin
                  // Bits 15..12 of group two are never stored
                  s_d.grp[g].fnc[15:8] = merge8(s_q.grp[g].fnc[15:8],
                     WB_DAT_I[15:8], lane_hi, fm[15:8]);
                  s_d.grp[g].fnc[7:0] = merge8(s_q.grp[g].fnc[7:0],
                     WB_DAT_I[7:0], lane_lo, fm[7:0]);
               end
               default:
               begin
                  clr = 8'h00;
               end
            endcase
         end
         // A fresh edge beats a clear in the same cycle
         s_d.grp[g].flag = ((s_q.grp[g].flag & ~clr) | ev[g]) &
                           GRP_MASK[g];
      end
   end

   // All fields reset to zero
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // Interrupt path per group
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_filt
         gpg_filter #(
            .N       (8),
            .SAMPLES (FILT_SAMPLES)
         ) u_filt (
            .clk      (CORE_CLK),
            .rst_n    (RESET_N),
            .tick     (tick),
            .level_in (s_q.grp[g].pin & s_q.grp[g].ien),
            .filt_en  (s_q.grp[g].filt),
            .edge_sel (s_q.grp[g].edge_sel),
            .edge_ev  (ev[g])
         );
      end
   endgenerate

   assign IRQ = |(s_q.grp[0].flag & s_q.grp[0].ie) |
                |(s_q.grp[1].flag & s_q.grp[1].ie);

   // ----------------------------------------------------------------
   // Pin function multiplexer
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_grp
         for (genvar y = 0; y < 8; y++)
         begin : g_pin
            for (genvar f = 0; f < 4; f++)
            begin : g_fn
               assign route[g][f][y] = s_q.grp[g].mode[y] &&
                  (s_q.grp[g].fnc[2*y +: `GPG_FN_W] ==
                   `GPG_FN_W'(f));
            end
            always_comb
            begin
               if (!s_q.grp[g].mode[y])
               begin
                  pout[g][y]  = s_q.grp[g].out[y];
                  drive[g][y] = s_q.grp[g].oen[y];
               end
               else if (route[g][1][y])
               begin
                  pout[g][y]  = upm_out[g][y];
                  drive[g][y] = upm_drv[g][y];
               end
               else if (route[g][0][y])
               begin
                  pout[g][y]  = fn0_out[g][y];
                  drive[g][y] = FN0_DRV[g][y];
               end
               else
               begin
                  // Input-only and analog functions leave pin floating
                  pout[g][y]  = 1'b0;
                  drive[g][y] = 1'b0;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign WB_DAT_O    = {16'h0000, s_q.dat};
   assign WB_ACK_O    = s_q.ack;
   assign G1_PIN_OUT  = pout[0];
   assign G1_PIN_OE_N = ~drive[0];
   assign G1_PULL_EN  = s_q.grp[0].ren;
   assign G1_PULL_UP  = s_q.grp[0].pdir;
   assign G2_PIN_OUT  = pout[1][5:0];
   assign G2_PIN_OE_N = ~drive[1][5:0];
   assign G2_PULL_EN  = s_q.grp[1].ren[5:0];
   assign G2_PULL_UP  = s_q.grp[1].pdir[5:0];

   assign UPM1_IN = s_q.grp[0].pin & route[0][1];
   assign UPM2_IN = s_q.grp[1].pin[5:0] & route[1][1][5:0];

   assign EXTERNAL_CLOCK_INPUT = s_q.grp[0].pin[0] & route[0][0][0];
   assign TIMER1_EXT_CLOCK_A   = s_q.grp[0].pin[2] & route[0][0][2];
   assign TIMER1_EXT_CLOCK_B   = s_q.grp[0].pin[3] & route[0][0][3];
   assign EXTERNAL_VOLTAGE_DETECT_INPUT =
      s_q.grp[0].pin[1] & route[0][2][1];

   // Trigger idles high when its pin is not routed
   assign CONVERTER_TRIGGER_N =
      s_q.grp[1].pin[0] | ~route[1][0][0];
   assign CONVERTER_REFERENCE_SEL = route[1][2][1];
   assign CONVERTER_ANALOG_SEL    = route[1][2][5:2];

endmodule

// ===== common/gpg_cfg.svh
`ifndef GPG_CFG_SVH
`define GPG_CFG_SVH

// ----------------------------------------------------------------
// Address map, byte addresses of 32-bit words
// ----------------------------------------------------------------
`define GPG_G1_BASE       8'h00
`define GPG_G2_BASE       8'h20
`define GPG_SUMMARY_OFS   8'h40
`define GPG_GRP_SEL_MSB   7
`define GPG_GRP_SEL_LSB   5

// Register index inside a group, address bits 4..2
`define GPG_IDX_DATA      3'h0
`define GPG_IDX_IOEN      3'h1
`define GPG_IDX_PULL      3'h2
`define GPG_IDX_FLAG      3'h3
`define GPG_IDX_ICTL      3'h4
`define GPG_IDX_FILT      3'h5
`define GPG_IDX_MODE      3'h6
`define GPG_IDX_FNC       3'h7

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define GPG_HI_LSB        8
`define GPG_LO_LSB        0
`define GPG_FN_W          2
`define GPG_G1_MASK       8'hff
`define GPG_G2_MASK       8'h3f
`define GPG_G1_FN0_DRV    8'hc0
`define GPG_G2_FN0_DRV    8'h00
`define GPG_SUM_G1_BIT    0
`define GPG_SUM_G2_BIT    1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPG_BYTE_RST      8'h00
`define GPG_FNC_RST       16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GPG_CLK_NS        25
`define GPG_FILT_TICK_NS  1000
`define GPG_FILT_DIV      (`GPG_FILT_TICK_NS / `GPG_CLK_NS)
`define GPG_DIV_W         6
`define GPG_FILT_SAMPLES  4

`endif

// ===== common/gpg_pkg.sv
`include "gpg_cfg.svh"

package gpg_pkg;

   // One port group; the six-pin group keeps bits 7..6 of each byte field, and fnc bits 15..12, at zero
   typedef struct packed {
      logic [7:0]  out;
      logic [7:0]  ien;
      logic [7:0]  oen;
      logic [7:0]  pdir;
      logic [7:0]  ren;
      logic [7:0]  flag;
      logic [7:0]  edge_sel;
      logic [7:0]  ie;
      logic [7:0]  filt;
      logic [7:0]  mode;
      logic [15:0] fnc;
      logic [7:0]  pin;
   } gpg_grp_t;

   typedef struct packed {
      gpg_grp_t [1:0]         grp;
      logic                   ack;
      logic [15:0]            dat;
      logic [`GPG_DIV_W-1:0]  div;
   } gpg_state_t;

endpackage

// ===== hdl/gpg_filter.sv
`timescale 1ns/1ps
`include "gpg_cfg.svh"

module gpg_filter #(
   parameter int N       = 8,
   parameter int SAMPLES = `GPG_FILT_SAMPLES
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         tick,
   input  wire logic [N-1:0] level_in,
   input  wire logic [N-1:0] filt_en,
   input  wire logic [N-1:0] edge_sel,
   output logic      [N-1:0] edge_ev
);

   localparam int CW = (SAMPLES > 1) ? $clog2(SAMPLES) : 1;

   typedef struct packed {
      logic [N-1:0]          lvl;
      logic [N-1:0]          ev;
      logic [N-1:0][CW-1:0]  cnt;
   } gpg_filt_state_t;

   gpg_filt_state_t s_q;
   gpg_filt_state_t s_d;

   // ----------------------------------------------------------------
   // Noise filter and edge detection
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      for (int y = 0; y < N; y++)
      begin
         if (!filt_en[y])
         begin
            s_d.lvl[y] = level_in[y];
            s_d.cnt[y] = '0;
         end
         else if (level_in[y] == s_q.lvl[y])
         begin
            s_d.cnt[y] = '0;
         end
         else if (tick)
         begin
            // New level must persist over SAMPLES ticks
            if (s_q.cnt[y] == CW'(SAMPLES - 1))
            begin
               s_d.lvl[y] = level_in[y];
               s_d.cnt[y] = '0;
            end
            else
            begin
               s_d.cnt[y] = s_q.cnt[y] + CW'(1);
            end
         end
         // Select 0 catches rising, 1 catches falling
         s_d.ev[y] = (s_d.lvl[y] != s_q.lvl[y]) &&
                     (s_d.lvl[y] != edge_sel[y]);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign edge_ev = s_q.ev;

endmodule

// ===== bench/gpg_chk.sv
`timescale 1ns/1ps

module gpg_chk (
   input wire logic        CORE_CLK,
   input wire logic        RESET_N,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        IRQ,
   input wire logic [7:0]  G1_PIN_IN,
   input wire logic [5:0]  G2_PIN_OE_N,
   input wire logic        EXTERNAL_CLOCK_INPUT,
   input wire logic        TIMER1_EXT_CLOCK_A,
   input wire logic        TIMER1_EXT_CLOCK_B,
   input wire logic        CONVERTER_TRIGGER_N,
   input wire logic        CONVERTER_REFERENCE_SEL,
   input wire logic [3:0]  CONVERTER_ANALOG_SEL
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);
   logic rd;
   assign rd = WB_ACK_O && !WB_WE_I;
   property p_ack;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ack long");
   property p_res;
      rd && WB_ADR_I[4:0] inside {5'h0c, 5'h14, 5'h18}
         |-> WB_DAT_O[31:8] == 24'h000000;
   endproperty
   a_res: assert property (p_res) else $error("upper byte");
   property p_g2;
      rd && WB_ADR_I[7:5] == 3'h1 && WB_ADR_I[4:2] != 3'h7
         |-> (WB_DAT_O[15:14] | WB_DAT_O[7:6]) == 2'h0;
   endproperty
   a_g2: assert property (p_g2) else $error("group2 unused");
   property p_fnc2;
      rd && WB_ADR_I == 8'h3c |-> WB_DAT_O[15:12] == 4'h0;
   endproperty
   a_fnc2: assert property (p_fnc2) else $error("fnc2 top");
   property p_sum;
      rd && WB_ADR_I == 8'h40 |-> WB_DAT_O[15:2] == 14'h0000;
   endproperty
   a_sum: assert property (p_sum) else $error("summary bits");
   property p_fall;
      $fell(IRQ) |-> $past(WB_ACK_O && WB_WE_I)
         || $past(WB_ACK_O && WB_WE_I, 2);
   endproperty
   a_fall: assert property (p_fall) else $error("irq drop");
   property p_route;
      !(EXTERNAL_CLOCK_INPUT && !$past(G1_PIN_IN[0]) ||
        TIMER1_EXT_CLOCK_A && !$past(G1_PIN_IN[2]) ||
        TIMER1_EXT_CLOCK_B && !$past(G1_PIN_IN[3]));
   endproperty
   a_route: assert property (p_route) else $error("route pin");
   property p_adc;
      (CONVERTER_ANALOG_SEL & ~G2_PIN_OE_N[5:2]) == 4'h0 &&
      !(CONVERTER_REFERENCE_SEL && !G2_PIN_OE_N[1]) &&
      (CONVERTER_TRIGGER_N || G2_PIN_OE_N[0]);
   endproperty
   a_adc: assert property (p_adc) else $error("analog drive");
endmodule

bind gpg_top gpg_chk gpg_chk_inst (
   .CORE_CLK, .RESET_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
   .WB_DAT_O, .WB_ACK_O, .IRQ, .G1_PIN_IN, .G2_PIN_OE_N,
   .EXTERNAL_CLOCK_INPUT, .TIMER1_EXT_CLOCK_A, .TIMER1_EXT_CLOCK_B,
   .CONVERTER_TRIGGER_N, .CONVERTER_REFERENCE_SEL, .CONVERTER_ANALOG_SEL
);

// ===== bench/gpg_pads.sv
`timescale 1ns/1ps

module gpg_pads #(
   parameter int N = 8
) (
   input  wire logic         clk,
   input  wire logic [N-1:0] oe_n,
   input  wire logic [N-1:0] out,
   input  wire logic [N-1:0] pen,
   input  wire logic [N-1:0] pup,
   input  wire logic [N-1:0] ext,
   input  wire logic [N-1:0] ext_en,
   output logic      [N-1:0] pin
);
   logic [N-1:0] flt = '0;
   always @(posedge clk) flt <= ~flt;
   // Device drive wins, then external drive, then pull; an undriven unpulled pad wanders
   always_comb
      for (int i = 0; i < N; i++)
         pin[i] = !oe_n[i] ? out[i] : ext_en[i] ? ext[i]
                : pen[i] ? pup[i] : flt[i];
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic CORE_CLK = 0, RESET_N = 0, WB_CYC_I = 0, WB_STB_I = 0;
   logic WB_WE_I = 0, IRQ, WB_ACK_O, REMOTE_CTRL_OUTPUT = 0;
   logic REMOTE_CARRIER_PULSE = 0, EXTERNAL_CLOCK_INPUT;
   logic TIMER1_EXT_CLOCK_A, TIMER1_EXT_CLOCK_B, CONVERTER_TRIGGER_N;
   logic EXTERNAL_VOLTAGE_DETECT_INPUT, CONVERTER_REFERENCE_SEL;
   logic [3:0] WB_SEL_I = 0, CONVERTER_ANALOG_SEL;
   logic [7:0] WB_ADR_I = 0, G1_PIN_IN, G1_PIN_OUT, G1_PIN_OE_N;
   logic [7:0] G1_PULL_EN, G1_PULL_UP, UPM1_IN, ext1 = 0, en1 = 8'hff;
   logic [7:0] UPM1_OUT = 0, UPM1_DRV = 0;
   logic [5:0] G2_PIN_IN, G2_PIN_OUT, G2_PIN_OE_N, G2_PULL_EN;
   logic [5:0] G2_PULL_UP, UPM2_IN, UPM2_OUT = 0, UPM2_DRV = 0;
   logic [5:0] ext2 = 6'h3f, en2 = 6'h3f;
   logic [31:0] WB_DAT_I = 0, WB_DAT_O;
   logic [15:0] m [16];
   int failures = 0, samples_checked = 0;

   gpg_top #(.FILT_DIV(2), .FILT_SAMPLES(2)) gpg_top_inst (.*);
   gpg_pads #(.N(8)) gpg_pads_inst (.clk(CORE_CLK), .oe_n(G1_PIN_OE_N),
      .out(G1_PIN_OUT), .pen(G1_PULL_EN), .pup(G1_PULL_UP), .ext(ext1),
      .ext_en(en1), .pin(G1_PIN_IN));
   gpg_pads #(.N(6)) gpg_pads2_inst (.clk(CORE_CLK), .oe_n(G2_PIN_OE_N),
      .out(G2_PIN_OUT), .pen(G2_PULL_EN), .pup(G2_PULL_UP), .ext(ext2),
      .ext_en(en2), .pin(G2_PIN_IN));

   initial
   begin
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   // Peripheral side keeps moving so routing is seen in earnest
   always @(posedge CORE_CLK)
      {UPM1_OUT, UPM1_DRV, UPM2_OUT, UPM2_DRV, REMOTE_CTRL_OUTPUT,
       REMOTE_CARRIER_PULSE} <= 30'($urandom);

   task automatic complete_run;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [31:0] q);
      @(posedge CORE_CLK);
      {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I} <= {2'b11, w, a};
      WB_SEL_I <= {2'($urandom), 2'b11};
      WB_DAT_I <= {16'($urandom), d};
      do @(posedge CORE_CLK); while (WB_ACK_O !== 1'b1);
      q = WB_DAT_O;
      {WB_CYC_I, WB_STB_I} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
                     input logic [15:0] mk = 16'hffff);
      logic [31:0] q;
      wb(1'b0, a, 16'h0000, q);
      chk(q & {16'h0000, mk}, {16'h0000, e & mk});
   endtask
   function automatic logic [15:0] msk(input int k);
      case (k)
         0: return 16'hff00;
         3, 5, 6: return 16'h00ff;
         8: return 16'h3f00;
         11, 13, 14: return 16'h003f;
         15: return 16'h0fff;
         default: return k < 8 ? 16'hffff : 16'h3f3f;
      endcase
   endfunction
   function automatic logic [7:0] ad(input int k);
      return {2'b00, 4'(k), 2'b00};
   endfunction
   task automatic rst_chk;
      RESET_N <= 0;
      repeat (12) @(posedge CORE_CLK);
      RESET_N <= 1;
      for (int k = 0; k < 16; k++)
      begin
         m[k] = 16'h0000;
         rd(ad(k), 16'h0000);
      end
      rd(8'h40, 16'h0000);
      rd(8'h41, 16'h0000);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge CORE_CLK);
   endtask

   initial
   begin
      #500000;
      failures++;
      complete_run();
   end

   initial
   begin
      void'($urandom(58818));
      rst_chk();
      // ---------------------------------------------------------------
      // Random read/write of control words
      // ---------------------------------------------------------------
      repeat (3)
      begin
         for (int k = 0; k < 16; k++)
            if (k % 8 != 3)
            begin
               m[k] = 16'($urandom) & msk(k);
               wr(ad(k), m[k]);
            end
         for (int k = 0; k < 16; k++)
            if (k % 8 != 3)
               rd(ad(k), m[k], msk(k));
         chk({G1_PULL_UP, G1_PULL_EN}, m[2]);
         chk({2'b00, G2_PULL_UP, 2'b00, G2_PULL_EN}, m[10]);
      end
      rst_chk();
      // ---------------------------------------------------------------
      // GPIO drive and readback
      // ---------------------------------------------------------------
      ext1 <= 8'($urandom);
      wr(8'h04, 16'hff0f);
      wr(8'h00, 16'ha500);
      wt(2);
      chk(G1_PIN_OE_N, 8'hf0);
      rd(8'h00, {8'ha5, ext1[7:4], 4'h5});
      wr(8'h04, 16'h000f);
      rd(8'h00, 16'ha500);
      en1 <= 8'h00;
      wr(8'h08, 16'hf0ff);
      wr(8'h04, 16'hff00);
      rd(8'h00, 16'ha5f0);
      // ---------------------------------------------------------------
      // Interrupt set, mask, clear
      // ---------------------------------------------------------------
      ext1 <= 8'h00;
      en1 <= 8'hff;
      wr(8'h04, 16'hff00);
      wr(8'h10, 16'h0001);
      wr(8'h0c, 16'h00ff);
      rd(8'h0c, 16'h0000);
      ext1[0] <= 1'b1;
      wt(6);
      chk(IRQ, 1'b1);
      rd(8'h0c, 16'h0001);
      rd(8'h40, 16'h0001);
      wr(8'h10, 16'h0000);
      wt(1);
      chk(IRQ, 1'b0);
      wr(8'h0c, 16'h0000);
      rd(8'h0c, 16'h0001);
      wr(8'h10, 16'h0001);
      wr(8'h0c, 16'h0001);
      wt(1);
      chk(IRQ, 1'b0);
      rd(8'h40, 16'h0000);
      wr(8'h24, 16'h3f00);
      wr(8'h30, 16'h0101);
      wr(8'h2c, 16'h003f);
      ext2[0] <= 1'b0;
      wt(6);
      rd(8'h2c, 16'h0001);
      rd(8'h40, 16'h0002);
      chk(IRQ, 1'b1);
      wr(8'h2c, 16'h0001);
      // ---------------------------------------------------------------
      // Noise filter: short glitch ignored, steady level accepted
      // ---------------------------------------------------------------
      wr(8'h14, 16'h0004);
      wr(8'h10, 16'h0004);
      wr(8'h0c, 16'h00ff);
      ext1[2] <= 1'b1;
      @(posedge CORE_CLK);
      ext1[2] <= 1'b0;
      wt(20);
      rd(8'h0c, 16'h0000);
      ext1[2] <= 1'b1;
      wt(20);
      rd(8'h0c, 16'h0004);
      // ---------------------------------------------------------------
      // Peripheral function routing
      // ---------------------------------------------------------------
      ext1 <= 8'h0f;
      ext2 <= 6'h00;
      wr(8'h04, 16'hff00);
      wr(8'h18, 16'h00df);
      wr(8'h1c, 16'h0108);
      wr(8'h24, 16'h3f00);
      wr(8'h38, 16'h003f);
      wr(8'h3c, 16'h0aa8);
      wt(3);
      chk({EXTERNAL_CLOCK_INPUT, EXTERNAL_VOLTAGE_DETECT_INPUT,
           TIMER1_EXT_CLOCK_A, TIMER1_EXT_CLOCK_B}, 4'hf);
      chk(G1_PIN_OE_N[3:0], 4'hf);
      chk({G1_PIN_OE_N[7:6], G1_PIN_OUT[7:6], G1_PIN_OE_N[4], G1_PIN_OUT[4]},
          {2'b00, REMOTE_CARRIER_PULSE, REMOTE_CTRL_OUTPUT,
           ~UPM1_DRV[4], UPM1_OUT[4]});
      chk(UPM1_IN & 8'hef, 8'h00);
      chk({CONVERTER_REFERENCE_SEL, CONVERTER_ANALOG_SEL}, 5'h1f);
      chk({CONVERTER_TRIGGER_N, G2_PIN_OE_N}, 7'h3f);
      chk({UPM2_IN, G2_PIN_OUT}, 12'h000);
      @(posedge CORE_CLK);
      ext2[0] <= 1'b1;
      wt(3);
      chk(CONVERTER_TRIGGER_N, 1'b1);
      wr(8'h18, 16'h00de);
      wt(2);
      chk({EXTERNAL_CLOCK_INPUT, G1_PIN_OE_N[0]}, 2'b01);
      complete_run();
   end
endmodule
